// ==== inc/tps_pkg.sv ====
// Purpose: Shared constants and pin groupings of the test pattern sequencer.
// Assumes: 25 MHz board clock, byte-wide pattern memory, two external pattern queues.
// Notes:   Every figure that more than one file needs is named here once.
package tps_pkg;

  // ----------------------------------------------------------------------
  // Pattern memory geometry
  // ----------------------------------------------------------------------
  localparam int IDX_W = 8;
  localparam int LOW_W = 11;
  localparam int PROM_AW = IDX_W + LOW_W;
  localparam int BYTE_W = 8;
  localparam int WORD_W = 32;
  localparam int BYTES_PER_PATTERN = 2048;
  localparam int WORDS_PER_PATTERN = 512;
  localparam logic [LOW_W-1:0] LAST_BYTE_ADDR = 11'h7ff;
  localparam logic [1:0] LAST_BYTE_OF_WORD = 2'h3;
  localparam logic [IDX_W-1:0] RESET_INDEX = 8'h00;

  // ----------------------------------------------------------------------
  // Pattern word layout
  // ----------------------------------------------------------------------
  localparam int CTRL_W = 7;
  localparam int DATA_W = 22;
  localparam int DATA_LSB = 0;
  localparam int CTRL_LSB = 22;

  // ----------------------------------------------------------------------
  // Counters and timing
  // ----------------------------------------------------------------------
  localparam int CNT_W = 10;
  localparam logic [CNT_W-1:0] WORDS_TARGET = 10'h200;
  localparam logic [8:0] LAST_READ = 9'h1ff;
  localparam int CLK_KHZ = 25000;
  localparam int PROM_ACCESS_NS = 120;
  localparam int PROM_WAIT_CYCLES = (PROM_ACCESS_NS * CLK_KHZ + 999999) / 1000000;
  localparam logic [2:0] PROM_WAIT_LAST = 3'(PROM_WAIT_CYCLES - 1);
  localparam int DEBOUNCE_US = 10000;
  localparam int DEBOUNCE_CYCLES = DEBOUNCE_US * (CLK_KHZ / 1000);
  localparam int BUF_DEPTH = 8;

  // ----------------------------------------------------------------------
  // Pin groups and sequencer state encoding
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic reset_n;
    logic s1_n;
    logic cke1;
    logic odt1;
    logic s0_n;
    logic cke0;
    logic odt0;
  } tps_ctrl_s;

  typedef struct packed {
    logic [15:0] a;
    logic [2:0] ba;
    logic we_n;
    logic ras_n;
    logic cas_n;
  } tps_addr_s;

  typedef enum logic [5:0] {
    ST_CAPTURE = 6'b00_0001,
    ST_FETCH = 6'b00_0010,
    ST_PUSH = 6'b00_0100,
    ST_DRAIN = 6'b00_1000,
    ST_MARK = 6'b01_0000,
    ST_RUN = 6'b10_0000
  } tps_state_e;

endpackage

// ==== hw/tps_fifo.sv ====
// Purpose: Small first-in first-out buffer with valid and ready on both sides.
// Assumes: Single clock, asynchronous active-high reset.
// Notes:   Storage is flip-flops; full and empty follow the true occupancy.
module tps_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wr_ptr;
  logic [PW-1:0] rd_ptr;
  logic [PW:0] count;

  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;
  wire [PW-1:0] next_wr_ptr = (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
  wire [PW-1:0] next_rd_ptr = (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;

  assign in_ready = (count != (PW + 1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data = mem[rd_ptr];

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) wr_ptr <= next_wr_ptr;
      if (pop) rd_ptr <= next_rd_ptr;
      if (push && !pop) count <= count + 1'b1;
      else if (pop && !push) count <= count - 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (push) mem[wr_ptr] <= in_data;
  end

endmodule

// ==== hw/tps_sequencer.sv ====
// Purpose: Loads a 512-word pattern from byte-wide memory into two queues and replays it.
// Assumes: Queues read with one cycle latency and support mark and retransmit.
// Notes:   Pattern contents are wholly defined by the memory image.
// Function
// R1: Switch index drives upper eight memory address lines.
// R2: Power-on or start button makes master reset.
// R3: Fetch each 32-bit word as four byte reads.
// R4: Full word written to both queues together.
// R5: Load stops after exactly 512 stored words.
// R6: Test mode reads queues every clock cycle.
// R7: Mark and retransmit replay pattern endlessly.
// R8: Replay continues until start button pressed again.
// R9: Index sampled only at master reset.
// R10: Each queue word shown exactly one cycle.
// R11: Control field bit order RESET# down to ODT0.
// R12: Data field carries A15..A0, BA2..BA0, WE#, RAS#, CAS#.
// R13: Queue outputs feed separate control and data registers.
// R14: Sync pattern passes unchanged every 32 cycles.
// R15: Lower eleven address lines step 2048 bytes.
// R16: Debounced button pulse clears queues and counters.
// R17: Mark at first word, retransmit at 512th.
module tps_sequencer #(
  parameter int DEBOUNCE_CYCLES = tps_pkg::DEBOUNCE_CYCLES
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic start_button,
  input wire logic [tps_pkg::IDX_W-1:0] pattern_index,
  output logic [tps_pkg::PROM_AW-1:0] prom_addr,
  output logic prom_oe_n,
  input wire logic [tps_pkg::BYTE_W-1:0] prom_data,
  output logic queue_reset,
  output logic queue_write,
  input wire logic queue_full,
  output tps_pkg::tps_ctrl_s control_queue_input,
  output tps_pkg::tps_addr_s address_queue_input,
  output logic queue_read,
  output logic queue_mark,
  output logic queue_retransmit,
  input wire tps_pkg::tps_ctrl_s control_queue_output,
  input wire tps_pkg::tps_addr_s address_queue_output,
  output tps_pkg::tps_ctrl_s dimm_control,
  output tps_pkg::tps_addr_s dimm_address,
  output logic test_active
);

  // ----------------------------------------------------------------------
  // Start button conditioning
  // ----------------------------------------------------------------------
  // The button is treated as asynchronous bounce-prone contact, so it is
  // synchronised and must be stable for the whole debounce interval.
  logic btn_meta;
  logic btn_sync;
  logic btn_level;
  logic [17:0] btn_cnt;
  logic btn_pulse;

  wire btn_differs = (btn_sync != btn_level);
  wire btn_settled = (btn_cnt == 18'(DEBOUNCE_CYCLES - 1));

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      btn_meta <= 1'b0;
      btn_sync <= 1'b0;
    end else begin
      btn_meta <= start_button;
      btn_sync <= btn_meta;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      btn_cnt <= '0;
      btn_level <= 1'b0;
      btn_pulse <= 1'b0;
    end else begin
      btn_pulse <= 1'b0;
      if (!btn_differs) begin
        btn_cnt <= '0;
      end else if (btn_settled) begin
        btn_cnt <= '0;
        btn_level <= btn_sync;
        btn_pulse <= btn_sync; // R16
      end else begin
        btn_cnt <= btn_cnt + 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Sequencer state
  // ----------------------------------------------------------------------
  tps_pkg::tps_state_e state;
  tps_pkg::tps_state_e next_state;
  logic [tps_pkg::IDX_W-1:0] index_q;
  logic [tps_pkg::LOW_W-1:0] byte_addr;
  logic [2:0] wait_cnt;
  logic [23:0] byte_shift;
  logic [tps_pkg::CNT_W-1:0] write_count;
  logic [8:0] read_count;
  logic read_d;

  logic buf_in_ready;
  logic buf_out_valid;
  logic [tps_pkg::WORD_W-1:0] buf_out_data;

  wire in_capture = (state == tps_pkg::ST_CAPTURE);
  wire in_fetch = (state == tps_pkg::ST_FETCH);
  wire in_push = (state == tps_pkg::ST_PUSH);
  wire in_run = (state == tps_pkg::ST_RUN);
  wire loading = in_fetch || in_push;
  wire wait_done = (wait_cnt == tps_pkg::PROM_WAIT_LAST);
  wire word_boundary = (byte_addr[1:0] == tps_pkg::LAST_BYTE_OF_WORD);
  wire last_byte = (byte_addr == tps_pkg::LAST_BYTE_ADDR);
  wire [tps_pkg::WORD_W-1:0] assembled = {byte_shift, prom_data}; // R3
  wire buf_push = in_push && buf_in_ready;
  wire byte_step = (in_fetch && wait_done && !word_boundary) || buf_push;
  wire all_written = (write_count == tps_pkg::WORDS_TARGET);
  wire drain_ok = buf_out_valid && (in_capture || (!queue_full && !all_written));
  wire last_read = in_run && (read_count == tps_pkg::LAST_READ);

  // Capture holds until the word buffer is empty. Words left by a load that
  // the button cut short are dropped there and never reach the new pattern.
  always_comb begin
    next_state = state;
    unique case (state)
      tps_pkg::ST_CAPTURE: begin
        if (!buf_out_valid) next_state = tps_pkg::ST_FETCH; // R16
      end
      tps_pkg::ST_FETCH: begin
        if (wait_done && word_boundary) next_state = tps_pkg::ST_PUSH;
      end
      tps_pkg::ST_PUSH: begin
        if (buf_in_ready) begin
          next_state = last_byte ? tps_pkg::ST_DRAIN : tps_pkg::ST_FETCH; // R4 R5
        end
      end
      tps_pkg::ST_DRAIN: begin
        if (all_written) next_state = tps_pkg::ST_MARK; // R6
      end
      tps_pkg::ST_MARK: next_state = tps_pkg::ST_RUN;
      tps_pkg::ST_RUN: next_state = tps_pkg::ST_RUN; // R8
    endcase
  end

  // A new master reset from the button wins over every state. The power-on
  // reset lands in the capture state as well, so both start a load.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= tps_pkg::ST_CAPTURE; // R2
    end else if (btn_pulse) begin
      state <= tps_pkg::ST_CAPTURE; // R2 R8
    end else begin
      state <= next_state;
    end
  end

  // The index is caught in every cycle of the capture state, never later,
  // so switch changes during a test are ignored.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      index_q <= tps_pkg::RESET_INDEX;
    end else if (in_capture) begin
      index_q <= pattern_index; // R9
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      byte_addr <= '0;
      wait_cnt <= '0;
      byte_shift <= '0;
    end else if (in_capture) begin
      byte_addr <= '0; // R16
      wait_cnt <= '0;
    end else if (in_fetch) begin
      wait_cnt <= wait_done ? wait_cnt : wait_cnt + 1'b1;
      if (byte_step) begin
        byte_shift <= assembled[23:0]; // R3
        byte_addr <= byte_addr + 1'b1; // R15
        wait_cnt <= '0;
      end
    end else if (buf_push) begin
      byte_addr <= byte_addr + 1'b1; // R15
      wait_cnt <= '0;
    end
  end

  assign prom_addr = {index_q, byte_addr}; // R1 R15
  assign prom_oe_n = !loading;

  // ----------------------------------------------------------------------
  // Word buffer and queue writes
  // ----------------------------------------------------------------------
  // The queue full flag stalls the drain side, which in turn stalls the
  // byte fetch once the small buffer fills.
  tps_fifo #(
    .WIDTH(tps_pkg::WORD_W),
    .DEPTH(tps_pkg::BUF_DEPTH)
  ) u_word_buf (
    .clk(clk),
    .sys_rst(sys_rst),
    .in_valid(in_push),
    .in_ready(buf_in_ready),
    .in_data(assembled),
    .out_valid(buf_out_valid),
    .out_ready(drain_ok),
    .out_data(buf_out_data)
  );

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      queue_write <= 1'b0;
      control_queue_input <= '0;
      address_queue_input <= '0;
      write_count <= '0;
    end else begin
      queue_write <= drain_ok && !in_capture; // R4
      if (drain_ok) begin
        control_queue_input <= buf_out_data[tps_pkg::CTRL_LSB +: tps_pkg::CTRL_W]; // R11
        address_queue_input <= buf_out_data[tps_pkg::DATA_LSB +: tps_pkg::DATA_W]; // R12
      end
      if (in_capture) write_count <= '0; // R16
      else if (drain_ok) write_count <= write_count + 1'b1; // R5
    end
  end

  // ----------------------------------------------------------------------
  // Replay
  // ----------------------------------------------------------------------
  assign queue_reset = in_capture; // R16
  assign queue_mark = (state == tps_pkg::ST_MARK); // R17
  assign queue_read = in_run; // R6
  assign queue_retransmit = last_read; // R7 R17
  assign test_active = in_run;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      read_count <= '0;
      read_d <= 1'b0;
    end else begin
      read_d <= queue_read && !btn_pulse;
      if (!in_run) read_count <= '0;
      else read_count <= read_count + 1'b1; // R7
    end
  end

  // Words pass through untouched, so a periodic sync pattern in memory
  // reaches both registers in the same cycle.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      dimm_control <= '0;
      dimm_address <= '0;
    end else if (read_d) begin
      dimm_control <= control_queue_output; // R10 R13 R14
      dimm_address <= address_queue_output; // R10 R13 R14
    end else begin
      dimm_control <= '0;
      dimm_address <= '0;
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  AST_INDEX_ADDR: assert property (@(posedge clk) disable iff (sys_rst) // R1
    loading |-> prom_addr[tps_pkg::PROM_AW-1:tps_pkg::LOW_W] == index_q)
    else $error("upper memory address differs from captured index");

  AST_BUTTON_RESTART: assert property (@(posedge clk) disable iff (sys_rst) // R2
    btn_pulse |=> queue_reset && prom_oe_n && !test_active)
    else $error("button pulse did not restart loading");

  AST_WORD_PUSH: assert property (@(posedge clk) disable iff (sys_rst) // R3
    buf_push |-> byte_addr[1:0] == tps_pkg::LAST_BYTE_OF_WORD)
    else $error("word pushed before four bytes were read");

  AST_BOTH_QUEUES: assert property (@(posedge clk) disable iff (sys_rst) // R4
    drain_ok && !in_capture |=> queue_write &&
      control_queue_input == $past(buf_out_data[tps_pkg::CTRL_LSB +: tps_pkg::CTRL_W]) &&
      address_queue_input == $past(buf_out_data[tps_pkg::DATA_LSB +: tps_pkg::DATA_W]))
    else $error("queue write did not carry both fields");

  AST_WORD_LIMIT: assert property (@(posedge clk) disable iff (sys_rst) // R5
    (state == tps_pkg::ST_MARK) |-> write_count == tps_pkg::WORDS_TARGET)
    else $error("test mode entered without exactly 512 words");

  AST_READ_EVERY: assert property (@(posedge clk) disable iff (sys_rst) // R6
    queue_mark && !btn_pulse |=> queue_read [*8])
    else $error("queue read not continuous in test mode");

  // Separate tally of reads since the mark. It shares no logic with the
  // replay counter, so a wrong wrap point there is caught here.
  logic [8:0] chk_reads;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      chk_reads <= '0;
    end else if (queue_mark) begin
      chk_reads <= '0;
    end else if (queue_read) begin
      chk_reads <= chk_reads + 1'b1;
    end
  end

  AST_RETRANSMIT: assert property (@(posedge clk) disable iff (sys_rst) // R7
    queue_read |-> queue_retransmit == (chk_reads == tps_pkg::LAST_READ))
    else $error("retransmit not at 512th read");

  AST_INDEX_HOLD: assert property (@(posedge clk) disable iff (sys_rst) // R9
    !in_capture |=> $stable(index_q))
    else $error("index changed outside master reset");

  AST_PIN_REG: assert property (@(posedge clk) disable iff (sys_rst) // R10
    read_d |=> dimm_address == $past(address_queue_output) &&
      dimm_control == $past(control_queue_output))
    else $error("queue word not presented for its cycle");

  AST_MARK_FIRST: assert property (@(posedge clk) disable iff (sys_rst) // R17
    queue_mark |-> !queue_read && read_count == '0)
    else $error("mark not set before first read");

  AST_FLUSH_DONE: assert property (@(posedge clk) disable iff (sys_rst) // R16
    in_capture && !buf_out_valid && !btn_pulse |=> in_fetch)
    else $error("load did not start after buffer was empty");

  AST_ONE_PULSE: assert property (@(posedge clk) disable iff (sys_rst) // R16
    btn_pulse |=> !btn_pulse)
    else $error("button press gave more than one pulse");

  AST_ADDR_STEP: assert property (@(posedge clk) disable iff (sys_rst) // R15
    byte_step || buf_push |=> byte_addr == $past(byte_addr) + 11'h001)
    else $error("byte address did not step by one");

  AST_FULL_STALL: assert property (@(posedge clk) disable iff (sys_rst) // R4
    queue_full |=> !queue_write)
    else $error("queue written while full");

  AST_RUN_NO_WRITE: assert property (@(posedge clk) disable iff (sys_rst) // R5
    in_run |-> !queue_write)
    else $error("queue written during replay");

  AST_DIMM_IDLE: assert property (@(posedge clk) disable iff (sys_rst) // R10
    !read_d |=> dimm_control == '0 && dimm_address == '0)
    else $error("pins not idle without a read");

endmodule

// ==== tb/tps_partner.sv ====
// Purpose: Behavioural pattern memory and the two pattern queues beside the sequencer.
// Assumes: Memory data settles two cycles after an address change; queues read in one cycle.
// Notes:   Queue full is commanded by the bench so that back-pressure can be exercised.
module tps_partner (
  input wire logic clk,
  input wire logic [18:0] prom_addr,
  input wire logic prom_oe_n,
  output logic [7:0] prom_data,
  input wire logic queue_reset,
  input wire logic queue_write,
  input wire logic stall,
  output logic queue_full,
  input wire logic [28:0] wr_word,
  input wire logic queue_read,
  input wire logic queue_mark,
  input wire logic queue_retransmit,
  output logic [28:0] rd_word
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [18:0] last_a = 19'h7_ffff;
  logic [1:0] age = 2'h0;
  logic [9:0] wp, rp, mp;
  logic [28:0] mem [0:1023];
  logic [7:0] byte_val;
  // A deselected memory, or one in the cycle after it sees a new address, shows inverted data, so an early sample is caught.
  assign byte_val = prom_addr[7:0] ^ prom_addr[18:11] ^ {prom_addr[10:8], 5'h00};
  assign prom_data = (!prom_oe_n && age >= 2'h1) ? byte_val : ~byte_val;
  assign queue_full = stall || (wp == 10'h3ff);
  always_ff @(posedge clk) begin
    if (prom_addr != last_a) begin
      last_a <= prom_addr;
      age <= 2'h0;
    end else if (age != 2'h3) begin
      age <= age + 2'h1;
    end
    if (queue_reset) begin
      wp <= 10'h000;
      rp <= 10'h000;
      mp <= 10'h000;
    end else begin
      if (queue_write) begin
        mem[wp] <= wr_word;
        wp <= wp + 10'h001;
      end
      if (queue_mark) begin
        mp <= rp;
      end
      if (queue_read) begin
        rd_word <= mem[rp];
        rp <= queue_retransmit ? mp : rp + 10'h001;
      end
    end
  end
endmodule

// ==== tb/tb_test_pattern_sequencer.sv ====
// Purpose: Self-checking bench of the pattern sequencer against the memory and queue model.
// Assumes: Debounce shortened to 4 cycles; bench inputs change only at rising edges.
// Notes:   Expected words are rebuilt from the memory image formula, never from the design.
module tb_test_pattern_sequencer;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, sys_rst, start_button, btn_next, rst_next, stall, stall_en;
  logic [7:0] pattern_index, idx_next, prom_data;
  logic [18:0] prom_addr;
  logic prom_oe_n, queue_reset, queue_write, queue_full, queue_read;
  logic queue_mark, queue_retransmit, test_active;
  logic [28:0] rd_word;
  tps_pkg::tps_ctrl_s control_queue_input, dimm_control;
  tps_pkg::tps_addr_s address_queue_input, dimm_address;
  int cyc = 0;
  int n_fail = 0;
  int compares = 0;

  tps_sequencer #(.DEBOUNCE_CYCLES(4)) uut (
    .clk(clk),
    .sys_rst(sys_rst),
    .start_button(start_button),
    .pattern_index(pattern_index),
    .prom_addr(prom_addr),
    .prom_oe_n(prom_oe_n),
    .prom_data(prom_data),
    .queue_reset(queue_reset),
    .queue_write(queue_write),
    .queue_full(queue_full),
    .control_queue_input(control_queue_input),
    .address_queue_input(address_queue_input),
    .queue_read(queue_read),
    .queue_mark(queue_mark),
    .queue_retransmit(queue_retransmit),
    .control_queue_output(rd_word[28:22]),
    .address_queue_output(rd_word[21:0]),
    .dimm_control(dimm_control),
    .dimm_address(dimm_address),
    .test_active(test_active)
  );

  tps_partner partner (
    .clk(clk),
    .prom_addr(prom_addr),
    .prom_oe_n(prom_oe_n),
    .prom_data(prom_data),
    .queue_reset(queue_reset),
    .queue_write(queue_write),
    .stall(stall),
    .queue_full(queue_full),
    .wr_word({control_queue_input, address_queue_input}),
    .queue_read(queue_read),
    .queue_mark(queue_mark),
    .queue_retransmit(queue_retransmit),
    .rd_word(rd_word)
  );

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc <= cyc + 1;
    sys_rst <= rst_next;
    start_button <= btn_next;
    pattern_index <= idx_next;
    stall <= stall_en && (cyc % 37 < 9);
  end

  function automatic logic [28:0] exp_word(input logic [7:0] idx, input int k);
    logic [31:0] w;
    logic [18:0] a;
    for (int b = 0; b < 4; b++) begin
      a = {idx, 11'(4 * k + b)};
      w = {w[23:0], a[7:0] ^ a[18:11] ^ {a[10:8], 5'h00}};
    end
    return w[28:0];
  endfunction

  task automatic check(input bit ok, input string msg);
    compares++;
    if (!ok) begin
      n_fail++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask

  task automatic stop_test();
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic tick();
    @(posedge clk);
    #1;
  endtask

  task automatic timeout(input string msg);
    check(1'b0, msg);
    stop_test();
  endtask

  task automatic run_load(input logic [7:0] idx);
    int writes;
    int n;
    bit prev_full;
    logic [10:0] top;
    writes = 0;
    n = 0;
    top = 11'h000;
    prev_full = queue_full;
    while (queue_mark !== 1'b1) begin
      tick();
      n++;
      if (n > 20000) timeout("load did not finish");
      if (queue_write === 1'b1) begin
        check(!prev_full, "write while queue full");
        check({control_queue_input, address_queue_input} === exp_word(idx, writes), "word");
        writes++;
      end
      if (prom_oe_n === 1'b0) begin
        check(prom_addr[18:11] === idx, "memory index bits wrong");
        if (prom_addr[10:0] > top) top = prom_addr[10:0];
      end
      prev_full = queue_full;
    end
    check(writes == 512, "word count wrong");
    check(top === 11'h7ff, "byte address range wrong");
    tick();
    check(queue_read === 1'b1 && test_active === 1'b1, "replay did not start");
    tick();
    check(dimm_control === '0 && dimm_address === '0, "pins not idle before first word");
  endtask

  task automatic check_replay(input logic [7:0] idx, input int first, input int cycles);
    for (int j = first; j < first + cycles; j++) begin
      tick();
      check({dimm_control, dimm_address} === exp_word(idx, j % 512), "pin word");
      check(queue_retransmit === ((j + 3) % 512 == 0), "retransmit misplaced");
      check(queue_write !== 1'b1 && queue_read === 1'b1 && test_active === 1'b1, "run");
    end
  endtask

  task automatic sc_reload(input logic [7:0] idx, input bit by_reset, input bit stalled);
    int n;
    idx_next = idx;
    stall_en = stalled;
    if (by_reset) rst_next = 1'b1;
    else btn_next = 1'b1;
    n = 0;
    while (queue_reset !== 1'b1) begin
      tick();
      n++;
      if (n > 40) timeout("master reset not seen");
    end
    check(prom_oe_n === 1'b1 && test_active === 1'b0, "not idle at master reset");
    if (by_reset) repeat (16) tick();
    rst_next = 1'b0;
    btn_next = 1'b0;
    run_load(idx);
    stall_en = 1'b0;
    check_replay(idx, 0, 1100);
  endtask

  // A press shorter than the debounce time must leave the running pattern untouched.
  task automatic sc_glitch();
    idx_next = 8'h41;
    btn_next = 1'b1;
    check_replay(8'h02, 1100, 2);
    btn_next = 1'b0;
    check_replay(8'h02, 1102, 60);
  endtask

  initial begin
    sys_rst = 1'b1;
    rst_next = 1'b1;
    start_button = 1'b0;
    btn_next = 1'b0;
    pattern_index = 8'h02;
    idx_next = 8'h02;
    stall = 1'b0;
    stall_en = 1'b0;
    sc_reload(8'h02, 1'b1, 1'b1);
    sc_glitch();
    sc_reload(8'h41, 1'b0, 1'b0);
    sc_reload(8'hc3, 1'b1, 1'b0);
    stop_test();
  end
endmodule
